// ===== design/peripheral_interrupt_expander.sv
// Functional notes
// - compare and timer1 requests to line two, group A
// - low-priority serial requests drive line five
// - line six: converter, then pins one-three
// - five external interrupt inputs provided
// - pin one control: level 1/6 or input
// - pin one rising or falling edge select
// - nonmaskable pin control: NMI or input
// - nonmaskable pin edge polarity selectable
// - pin two control: level 1/6 or I/O
// - pin three control: level 1/6 or I/O
// - pins two, three edge polarity selectable
// - power-drive protection tristates outputs, signals core
// - power-drive request maskable, level 2, mask 742Ch
// - flag plus enable gate sources into arbitration
// - empty acknowledge reads phantom offset zero
// - highest ranked source on a line first
//
// The address-and-strobe port was left to the implementer.
module peripheral_interrupt_expander
  import pie_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic [9:0] event_group_a_req,
  input wire logic [7:0] event_group_b_req,
  input wire logic [3:0] event_group_c_req,
  input wire logic serial_peripheral_request,
  input wire logic serial_receive_request,
  input wire logic serial_transmit_request,
  input wire logic converter_request,
  input wire logic ext_irq_one,
  input wire logic nonmaskable_pin,
  input wire logic ext_irq_two_in,
  output logic ext_irq_two_out,
  output logic ext_irq_two_oe,
  input wire logic ext_irq_three_in,
  output logic ext_irq_three_out,
  output logic ext_irq_three_oe,
  input wire logic power_drive_protect_n,
  output logic [5:0] core_int_lines,
  output logic core_nmi,
  output logic pwm_output_hiz,
  output logic irq
);

  logic [4:0] pins;
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  logic [2:0][15:0] x_ctrl_r;
  logic [2:0] x_flag_r;
  logic [15:0] nmi_ctrl_r;
  logic nmi_flag_r;
  logic [GA_N-1:0] ga_mask_r;
  logic [GA_N-1:0] ga_flag_r;
  logic [GB_N-1:0] gb_mask_r;
  logic [GB_N-1:0] gb_flag_r;
  logic [GC_N-1:0] gc_mask_r;
  logic [GC_N-1:0] gc_flag_r;
  logic [4:0] sys_ctrl_r;
  logic [3:0] sys_flag_r;
  logic [1:0] irq_en_r;
  logic [1:0] irq_stat_r;

  logic [2:0] x_set;
  logic nmi_set;
  logic [GA_N-1:0] ga_req;
  logic [GB_N-1:0] gb_req;
  logic [GC_N-1:0] gc_req;
  logic [SYS_N-1:0] sys_req;
  logic ga_any;
  logic gb_any;
  logic gc_any;
  logic sys_any;
  logic [15:0] ga_off;
  logic [15:0] gb_off;
  logic [15:0] gc_off;
  logic [15:0] sys_off;
  logic [GA_N-1:0] ga_oh;
  logic [GB_N-1:0] gb_oh;
  logic [GC_N-1:0] gc_oh;
  logic [SYS_N-1:0] sys_oh;
  logic ga_ack;
  logic gb_ack;
  logic gc_ack;
  logic sys_ack;
  logic phantom_read;
  logic [15:0] rd_val;
  logic serial_high;

  // all five external inputs come from pins and need synchronising
  assign pins = {power_drive_protect_n, nonmaskable_pin, ext_irq_three_in, ext_irq_two_in, ext_irq_one};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_pin
      pin_sync_edge #(
        .IDLE_LEVEL(1'b1)
      ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(pins[g]),
        .level(pin_lvl[g]),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      );
    end
  endgenerate

  // edge select; in general-purpose mode the pin raises nothing
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      x_set[i] = (x_ctrl_r[i][XC_RISE] ? pin_rise[i] : pin_fall[i]) & ~x_ctrl_r[i][XC_GPIO];
    end
    nmi_set = (nmi_ctrl_r[XC_RISE] ? pin_rise[PIN_NMI] : pin_fall[PIN_NMI]) & ~nmi_ctrl_r[XC_GPIO];
  end

  assign serial_high = sys_ctrl_r[SC_SERIAL_HIGH];

  // arbitration inputs: only flagged and enabled sources compete
  always_comb begin
    ga_req = ga_flag_r & ga_mask_r;
    gb_req = gb_flag_r & gb_mask_r;
    gc_req = gc_flag_r & gc_mask_r;
    for (int i = 0; i < 3; i++) begin
      sys_req[i] = x_flag_r[i] & x_ctrl_r[i][XC_EN] & ~x_ctrl_r[i][XC_GPIO] & ~x_ctrl_r[i][XC_LOW];
      sys_req[10 + i] = x_flag_r[i] & x_ctrl_r[i][XC_EN] & ~x_ctrl_r[i][XC_GPIO] & x_ctrl_r[i][XC_LOW];
    end
    for (int i = 0; i < 3; i++) begin
      sys_req[3 + i] = sys_flag_r[SF_SPI + i] & sys_ctrl_r[SC_SPI_EN + i] & serial_high;
      sys_req[6 + i] = sys_flag_r[SF_SPI + i] & sys_ctrl_r[SC_SPI_EN + i] & ~serial_high;
    end
    sys_req[9] = sys_flag_r[SF_ADC] & sys_ctrl_r[SC_ADC_EN];
  end

  prio_group #(
    .N(GA_N),
    .OFFS(GA_OFFS)
  ) u_grp_a (
    .req(ga_req),
    .any(ga_any),
    .offset(ga_off),
    .onehot(ga_oh)
  );

  prio_group #(
    .N(GB_N),
    .OFFS(GB_OFFS)
  ) u_grp_b (
    .req(gb_req),
    .any(gb_any),
    .offset(gb_off),
    .onehot(gb_oh)
  );

  prio_group #(
    .N(GC_N),
    .OFFS(GC_OFFS)
  ) u_grp_c (
    .req(gc_req),
    .any(gc_any),
    .offset(gc_off),
    .onehot(gc_oh)
  );

  prio_group #(
    .N(SYS_N),
    .OFFS(SYS_OFFS)
  ) u_grp_sys (
    .req(sys_req),
    .any(sys_any),
    .offset(sys_off),
    .onehot(sys_oh)
  );

  // reading a vector register acknowledges the winner and clears its flag
  assign ga_ack = rd_stb && addr == GA_VEC_ADDR;
  assign gb_ack = rd_stb && addr == GB_VEC_ADDR;
  assign gc_ack = rd_stb && addr == GC_VEC_ADDR;
  assign sys_ack = rd_stb && addr == SYS_VEC_ADDR;
  assign phantom_read = (ga_ack && !ga_any) || (gb_ack && !gb_any) || (gc_ack && !gc_any) ||
                        (sys_ack && !sys_any);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      x_ctrl_r <= {3{CTRL_RST}};
      nmi_ctrl_r <= CTRL_RST;
    end else if (wr_stb) begin
      for (int i = 0; i < 3; i++) begin
        if (addr == X_CTRL_ADDR[i]) begin
          x_ctrl_r[i] <= wdata & X_WMASK[i];
        end
      end
      if (addr == NMI_CTRL_ADDR) begin
        nmi_ctrl_r <= wdata & NMI_WMASK;
      end
    end
  end

  // pin flags: write one clears, a new edge in the same cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      x_flag_r <= '0;
      nmi_flag_r <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (x_set[i]) begin
          x_flag_r[i] <= 1'b1;
        end else if ((wr_stb && addr == X_CTRL_ADDR[i] && wdata[XC_FLAG]) ||
                     (sys_ack && (sys_oh[i] || sys_oh[10 + i]))) begin
          x_flag_r[i] <= 1'b0;
        end
      end
      if (nmi_set) begin
        nmi_flag_r <= 1'b1;
      end else if (wr_stb && addr == NMI_CTRL_ADDR && wdata[XC_FLAG]) begin
        nmi_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ga_mask_r <= MASK_RST[GA_N-1:0];
      gb_mask_r <= MASK_RST[GB_N-1:0];
      gc_mask_r <= MASK_RST[GC_N-1:0];
      sys_ctrl_r <= CTRL_RST[4:0];
      irq_en_r <= CTRL_RST[1:0];
    end else if (wr_stb) begin
      case (addr)
        GA_MASK_ADDR: ga_mask_r <= wdata[GA_N-1:0];
        GB_MASK_ADDR: gb_mask_r <= wdata[GB_N-1:0];
        GC_MASK_ADDR: gc_mask_r <= wdata[GC_N-1:0];
        SYS_CTRL_ADDR: sys_ctrl_r <= wdata[4:0];
        IRQ_EN_ADDR: irq_en_r <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // event group flags; bit 0 of group A is the power-drive request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ga_flag_r <= '0;
      gb_flag_r <= '0;
      gc_flag_r <= '0;
    end else begin
      ga_flag_r <= (ga_flag_r & ~((wr_stb && addr == GA_FLAG_ADDR) ? wdata[GA_N-1:0] : '0)
                   & ~(ga_ack ? ga_oh : '0)) | {event_group_a_req, pin_fall[PIN_PDP]};
      gb_flag_r <= (gb_flag_r & ~((wr_stb && addr == GB_FLAG_ADDR) ? wdata[GB_N-1:0] : '0)
                   & ~(gb_ack ? gb_oh : '0)) | event_group_b_req;
      gc_flag_r <= (gc_flag_r & ~((wr_stb && addr == GC_FLAG_ADDR) ? wdata[GC_N-1:0] : '0)
                   & ~(gc_ack ? gc_oh : '0)) | event_group_c_req;
    end
  end

  // serial and converter flags; either chain slot of a source clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_flag_r <= '0;
    end else begin
      sys_flag_r <= (sys_flag_r & ~((wr_stb && addr == SYS_FLAG_ADDR) ? wdata[3:0] : 4'h0)
                    & ~(sys_ack ? {sys_oh[9], sys_oh[5] | sys_oh[8], sys_oh[4] | sys_oh[7],
                                   sys_oh[3] | sys_oh[6]} : 4'h0))
                    | {converter_request, serial_transmit_request, serial_receive_request,
                       serial_peripheral_request};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_stb && addr == IRQ_CLR_ADDR) ? wdata[1:0] : 2'b00))
                    | {pin_fall[PIN_PDP], phantom_read};
    end
  end

  // core lines follow the arbiters one cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_int_lines <= '0;
      core_nmi <= 1'b0;
      pwm_output_hiz <= 1'b0;
      irq <= 1'b0;
    end else begin
      core_int_lines[0] <= |sys_req[5:0];
      core_int_lines[1] <= ga_any;
      core_int_lines[2] <= gb_any;
      core_int_lines[3] <= gc_any;
      core_int_lines[4] <= |sys_req[8:6];
      core_int_lines[5] <= |sys_req[12:9];
      core_nmi <= nmi_flag_r & nmi_ctrl_r[XC_EN] & ~nmi_ctrl_r[XC_GPIO];
      // outputs stay high-impedance while the trip flag and its group A mask bit are both set
      pwm_output_hiz <= ga_flag_r[0] & ga_mask_r[0];
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_irq_two_out <= 1'b0;
      ext_irq_two_oe <= 1'b0;
      ext_irq_three_out <= 1'b0;
      ext_irq_three_oe <= 1'b0;
    end else begin
      ext_irq_two_out <= x_ctrl_r[1][XC_DOUT];
      ext_irq_two_oe <= x_ctrl_r[1][XC_GPIO] & x_ctrl_r[1][XC_DIR];
      ext_irq_three_out <= x_ctrl_r[2][XC_DOUT];
      ext_irq_three_oe <= x_ctrl_r[2][XC_GPIO] & x_ctrl_r[2][XC_DIR];
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      if (addr == X_CTRL_ADDR[i]) begin
        rd_val = x_ctrl_r[i];
        rd_val[XC_PIN] = pin_lvl[i];
        rd_val[XC_FLAG] = x_flag_r[i];
      end
    end
    case (addr)
      NMI_CTRL_ADDR: begin
        rd_val = nmi_ctrl_r;
        rd_val[XC_PIN] = pin_lvl[PIN_NMI];
        rd_val[XC_FLAG] = nmi_flag_r;
      end
      GA_MASK_ADDR: rd_val[GA_N-1:0] = ga_mask_r;
      GB_MASK_ADDR: rd_val[GB_N-1:0] = gb_mask_r;
      GC_MASK_ADDR: rd_val[GC_N-1:0] = gc_mask_r;
      GA_FLAG_ADDR: rd_val[GA_N-1:0] = ga_flag_r;
      GB_FLAG_ADDR: rd_val[GB_N-1:0] = gb_flag_r;
      GC_FLAG_ADDR: rd_val[GC_N-1:0] = gc_flag_r;
      GA_VEC_ADDR: rd_val = ga_off;
      GB_VEC_ADDR: rd_val = gb_off;
      GC_VEC_ADDR: rd_val = gc_off;
      SYS_VEC_ADDR: rd_val = sys_off;
      SYS_CTRL_ADDR: rd_val[4:0] = sys_ctrl_r;
      SYS_FLAG_ADDR: rd_val[3:0] = sys_flag_r;
      IRQ_STAT_ADDR: rd_val[1:0] = irq_stat_r;
      IRQ_EN_ADDR: rd_val[1:0] = irq_en_r;
      default: ;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= RDATA_RST;
    end else begin
      rdata <= rd_stb ? rd_val : RDATA_RST;
    end
  end

endmodule : peripheral_interrupt_expander

// ===== design/pin_sync_edge.sv
module pin_sync_edge #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= IDLE_LEVEL;
      s2_r <= IDLE_LEVEL;
      s3_r <= IDLE_LEVEL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once two settled stages agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level <= IDLE_LEVEL;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2_r == s3_r && s2_r != level) begin
        level <= s2_r;
        rise <= s2_r;
        fall <= ~s2_r;
      end
    end
  end

endmodule : pin_sync_edge

// ===== design/prio_group.sv
module prio_group #(
  parameter int N = 4,
  parameter logic [N-1:0][15:0] OFFS = '0
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [15:0] offset,
  output logic [N-1:0] onehot
);

  // lowest index wins; no request yields the phantom offset
  always_comb begin
    any = |req;
    offset = 16'h0000;
    onehot = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        offset = OFFS[i];
        onehot = '0;
        onehot[i] = 1'b1;
      end
    end
  end

endmodule : prio_group

// ===== dv/core_line_model.sv
module core_line_model (
  input wire logic [5:0] core_int_lines,
  input wire logic core_nmi,
  output logic [2:0] top_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // the core takes the lowest numbered pending line; nmi beats all of them
  always_comb begin
    top_line = 3'h0;
    for (int k = 5; k >= 0; k--) begin
      if (core_int_lines[k]) begin
        top_line = 3'(k + 1);
      end
    end
    if (core_nmi) begin
      top_line = 3'h7;
    end
  end
endmodule : core_line_model

// ===== dv/peripheral_interrupt_expander_tb_top.sv
module peripheral_interrupt_expander_tb_top
  import pie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rdata;
  logic [9:0] ga_req = 10'h000;
  logic [7:0] gb_req = 8'h00;
  logic [3:0] gc_req = 4'h0;
  logic spi = 1'b0;
  logic rxr = 1'b0;
  logic txr = 1'b0;
  logic adc = 1'b0;
  logic p1 = 1'b1;
  logic p2 = 1'b1;
  logic p3 = 1'b1;
  logic nmi_pin = 1'b1;
  logic pdp_n = 1'b1;
  logic p2_out;
  logic p2_oe;
  logic p3_out;
  logic p3_oe;
  logic [5:0] lines;
  logic nmi;
  logic hiz;
  logic irq;
  logic [2:0] top_line;
  int miscompares = 0;
  int n_checks = 0;
  logic [15:0] mask_a [3] = '{GA_MASK_ADDR, GB_MASK_ADDR, GC_MASK_ADDR};
  logic [15:0] mask_v [3] = '{16'h07FE, 16'h00FF, 16'h000F};
  logic [15:0] vec_a [3] = '{GA_VEC_ADDR, GB_VEC_ADDR, GC_VEC_ADDR};
  logic [15:0] base [3] = '{16'h0021, 16'h002B, 16'h0033};
  int cnt [3] = '{10, 8, 4};

  always #20 clk = ~clk;

  peripheral_interrupt_expander dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .event_group_a_req(ga_req), .event_group_b_req(gb_req),
    .event_group_c_req(gc_req), .serial_peripheral_request(spi), .serial_receive_request(rxr),
    .serial_transmit_request(txr), .converter_request(adc), .ext_irq_one(p1), .nonmaskable_pin(nmi_pin),
    .ext_irq_two_in(p2), .ext_irq_two_out(p2_out), .ext_irq_two_oe(p2_oe), .ext_irq_three_in(p3),
    .ext_irq_three_out(p3_out), .ext_irq_three_oe(p3_oe), .power_drive_protect_n(pdp_n), .core_int_lines(lines),
    .core_nmi(nmi), .pwm_output_hiz(hiz), .irq(irq));
  core_line_model u_core (.core_int_lines(lines), .core_nmi(nmi), .top_line(top_line));

  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  task automatic lines_are(input logic [5:0] exp);
    chk({10'h000, lines}, {10'h000, exp});
  endtask : lines_are
  // sources pulse for one cycle; the line is due two cycles after the pulse
  task automatic pulse(input int g);
    @(posedge clk);
    case (g)
      0: ga_req <= 10'h3FF;
      1: gb_req <= 8'hFF;
      2: gc_req <= 4'hF;
      default: {spi, rxr, txr, adc} <= 4'hF;
    endcase
    @(posedge clk);
    {ga_req, gb_req, gc_req, spi, rxr, txr, adc} <= '0;
    cyc(1);
  endtask : pulse
  // pins go through a synchroniser, so allow a fixed settle span
  task automatic pin(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: p1 <= v;
      1: p2 <= v;
      2: p3 <= v;
      3: nmi_pin <= v;
      default: pdp_n <= v;
    endcase
    cyc(10);
  endtask : pin

  initial begin : watchdog
    repeat (4000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin : main
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(GA_MASK_ADDR, MASK_RST);
    rd(16'h1234, 16'h0000);
    for (int g = 0; g < 3; g++) begin
      wr(mask_a[g], mask_v[g]);
      pulse(g);
      lines_are(6'h02 << g);
      chk({13'h0000, top_line}, 16'(g + 2));
      for (int i = 0; i < cnt[g]; i++) begin
        rd(vec_a[g], base[g] + 16'(i));
      end
      rd(vec_a[g], PHANTOM_OFFSET);
      lines_are(6'h00);
    end
    chk({15'h0000, irq}, 16'h0000);
    wr(GC_MASK_ADDR, 16'h0000);
    pulse(2);
    lines_are(6'h00);
    rd(GC_FLAG_ADDR, 16'h000F);
    rd(GC_VEC_ADDR, PHANTOM_OFFSET);
    wr(GC_FLAG_ADDR, 16'h000F);
    rd(GC_FLAG_ADDR, 16'h0000);
    wr(SYS_CTRL_ADDR, 16'h000F);
    pulse(3);
    lines_are(6'h30);
    rd(SYS_VEC_ADDR, 16'h0005);
    rd(SYS_VEC_ADDR, 16'h0006);
    rd(SYS_VEC_ADDR, 16'h0007);
    rd(SYS_VEC_ADDR, 16'h0004);
    rd(SYS_VEC_ADDR, PHANTOM_OFFSET);
    wr(SYS_CTRL_ADDR, 16'h001F);
    pulse(3);
    lines_are(6'h21);
    rd(SYS_VEC_ADDR, 16'h0005);
    wr(SYS_FLAG_ADDR, 16'h000F);
    wr(X_CTRL_ADDR[0], 16'h0003);
    pin(0, 1'b0);
    lines_are(6'h20);
    rd(SYS_VEC_ADDR, 16'h0001);
    rd(X_CTRL_ADDR[0], 16'h0003);
    wr(X_CTRL_ADDR[1], 16'h0007);
    pin(1, 1'b0);
    lines_are(6'h00);
    pin(1, 1'b1);
    lines_are(6'h20);
    rd(SYS_VEC_ADDR, 16'h0011);
    wr(X_CTRL_ADDR[2], 16'h0001);
    pin(2, 1'b0);
    lines_are(6'h01);
    rd(SYS_VEC_ADDR, 16'h001F);
    wr(NMI_CTRL_ADDR, 16'h0005);
    pin(3, 1'b0);
    chk({15'h0000, nmi}, 16'h0000);
    pin(3, 1'b1);
    chk({15'h0000, nmi}, 16'h0001);
    wr(NMI_CTRL_ADDR, 16'h8005);
    cyc(3);
    chk({15'h0000, nmi}, 16'h0000);
    wr(X_CTRL_ADDR[1], 16'h0038);
    cyc(3);
    chk({14'h0000, p2_oe, p2_out}, 16'h0003);
    wr(X_CTRL_ADDR[2], 16'h0008);
    rd(X_CTRL_ADDR[2], 16'h0008);
    chk({14'h0000, p3_oe, p3_out}, 16'h0000);
    pin(2, 1'b1);
    rd(X_CTRL_ADDR[2], 16'h0048);
    lines_are(6'h00);
    wr(GA_MASK_ADDR, 16'h0001);
    wr(IRQ_EN_ADDR, 16'h0002);
    pin(4, 1'b0);
    chk({13'h0000, hiz, irq, lines[1]}, 16'h0007);
    rd(GA_VEC_ADDR, 16'h0020);
    cyc(2);
    chk({15'h0000, hiz}, 16'h0000);
    rd(IRQ_STAT_ADDR, 16'h0003);
    wr(IRQ_CLR_ADDR, 16'h0003);
    cyc(3);
    chk({15'h0000, irq}, 16'h0000);
    // general-purpose input modes must swallow pin edges
    wr(NMI_CTRL_ADDR, 16'h000D);
    pin(3, 1'b0);
    pin(3, 1'b1);
    chk({15'h0000, nmi}, 16'h0000);
    rd(NMI_CTRL_ADDR, 16'h004D);
    wr(X_CTRL_ADDR[0], 16'h0009);
    pin(0, 1'b1);
    pin(0, 1'b0);
    lines_are(6'h00);
    rd(X_CTRL_ADDR[0], 16'h0009);
    wr(X_CTRL_ADDR[2], 16'h0038);
    cyc(3);
    chk({14'h0000, p3_oe, p3_out}, 16'h0003);
    print_verdict();
  end
endmodule : peripheral_interrupt_expander_tb_top

// ===== dv/pie_monitor.sv
module pie_monitor
  import pie_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic [3:0] event_group_c_req,
  input wire logic serial_peripheral_request,
  input wire logic serial_receive_request,
  input wire logic serial_transmit_request,
  input wire logic nonmaskable_pin,
  input wire logic power_drive_protect_n,
  input wire logic ext_irq_two_oe,
  input wire logic [5:0] core_int_lines,
  input wire logic core_nmi,
  input wire logic pwm_output_hiz,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since each pin last moved; pins pass a synchroniser, so no exact figure
  logic nmi_q_r;
  logic pdp_q_r;
  logic [3:0] nmi_age_r;
  logic [3:0] pdp_age_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_q_r <= 1'b1;
      pdp_q_r <= 1'b1;
      nmi_age_r <= 4'hF;
      pdp_age_r <= 4'hF;
    end else begin
      nmi_q_r <= nonmaskable_pin;
      pdp_q_r <= power_drive_protect_n;
      nmi_age_r <= (nonmaskable_pin != nmi_q_r) ? 4'h0 : ((nmi_age_r == 4'hF) ? nmi_age_r : nmi_age_r + 4'h1);
      pdp_age_r <= (power_drive_protect_n != pdp_q_r) ? 4'h0 : ((pdp_age_r == 4'hF) ? pdp_age_r : pdp_age_r + 4'h1);
    end
  end
  sequence s_empty_ga_read;
    rd_stb && addr == GA_VEC_ADDR && !core_int_lines[1] ##1 !core_int_lines[1];
  endsequence
  sequence s_recent_write;
    $past(wr_stb, 1) || $past(wr_stb, 2);
  endsequence
  property p_phantom;
    s_empty_ga_read |-> rdata == PHANTOM_OFFSET;
  endproperty
  property p_c_rise;
    $rose(core_int_lines[3]) |-> $past(event_group_c_req, 2) != 4'h0 or s_recent_write;
  endproperty
  property p_five_rise;
    $rose(core_int_lines[4]) |-> s_recent_write or
      $past(serial_peripheral_request || serial_receive_request || serial_transmit_request, 2);
  endproperty
  property p_line_fall;
    |($past(core_int_lines) & ~core_int_lines) |-> $past(rd_stb || wr_stb, 2);
  endproperty
  property p_hiz_line;
    pwm_output_hiz |-> core_int_lines[1];
  endproperty
  property p_oe_write;
    $changed(ext_irq_two_oe) |-> s_recent_write;
  endproperty
  property p_nmi_rise;
    $rose(core_nmi) |-> s_recent_write or nmi_age_r <= 4'hA;
  endproperty
  property p_irq_rise;
    $rose(irq) |-> $past(rd_stb, 2) || pdp_age_r <= 4'hA or s_recent_write;
  endproperty
  a_phantom: assert property (p_phantom)
    else $error("empty group read gave a nonzero offset");
  a_c_rise: assert property (p_c_rise)
    else $error("capture line rose without cause");
  a_five_rise: assert property (p_five_rise)
    else $error("line five rose without serial request");
  a_line_fall: assert property (p_line_fall)
    else $error("core line fell without register access");
  a_hiz_line: assert property (p_hiz_line)
    else $error("outputs tristated without level two request");
  a_oe_write: assert property (p_oe_write)
    else $error("pin two drive enable moved without write");
  a_nmi_rise: assert property (p_nmi_rise)
    else $error("nmi rose without pin edge");
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt output rose without event");
endmodule : pie_monitor

bind peripheral_interrupt_expander pie_monitor u_mon (.clk, .sys_rst, .addr, .wr_stb, .rd_stb, .rdata,
  .event_group_c_req, .serial_peripheral_request, .serial_receive_request, .serial_transmit_request,
  .nonmaskable_pin, .power_drive_protect_n, .ext_irq_two_oe, .core_int_lines, .core_nmi, .pwm_output_hiz, .irq);

// ===== pkg/pie_pkg.sv
package pie_pkg;

  // register map, 16-bit word addresses
  localparam logic [15:0] SYS_VEC_ADDR = 16'h701E;
  localparam logic [15:0] SYS_CTRL_ADDR = 16'h7018;
  localparam logic [15:0] SYS_FLAG_ADDR = 16'h701A;
  localparam logic [15:0] NMI_CTRL_ADDR = 16'h7072;
  localparam logic [2:0][15:0] X_CTRL_ADDR = {16'h707A, 16'h7078, 16'h7070};
  localparam logic [15:0] GA_MASK_ADDR = 16'h742C;
  localparam logic [15:0] GB_MASK_ADDR = 16'h742D;
  localparam logic [15:0] GC_MASK_ADDR = 16'h742E;
  localparam logic [15:0] GA_FLAG_ADDR = 16'h742F;
  localparam logic [15:0] GB_FLAG_ADDR = 16'h7430;
  localparam logic [15:0] GC_FLAG_ADDR = 16'h7431;
  localparam logic [15:0] GA_VEC_ADDR = 16'h7432;
  localparam logic [15:0] GB_VEC_ADDR = 16'h7433;
  localparam logic [15:0] GC_VEC_ADDR = 16'h7434;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'h7040;
  localparam logic [15:0] IRQ_CLR_ADDR = 16'h7041;
  localparam logic [15:0] IRQ_EN_ADDR = 16'h7042;

  // external pin control fields
  localparam int XC_EN = 0;
  localparam int XC_LOW = 1;
  localparam int XC_RISE = 2;
  localparam int XC_GPIO = 3;
  localparam int XC_DIR = 4;
  localparam int XC_DOUT = 5;
  localparam int XC_PIN = 6;
  localparam int XC_FLAG = 15;
  localparam logic [2:0][15:0] X_WMASK = {16'h003F, 16'h003F, 16'h000F};
  localparam logic [15:0] NMI_WMASK = 16'h000D;

  // system control fields
  localparam int SC_SPI_EN = 0;
  localparam int SC_RX_EN = 1;
  localparam int SC_TX_EN = 2;
  localparam int SC_ADC_EN = 3;
  localparam int SC_SERIAL_HIGH = 4;

  // system flag positions
  localparam int SF_SPI = 0;
  localparam int SF_RX = 1;
  localparam int SF_TX = 2;
  localparam int SF_ADC = 3;

  // own interrupt events
  localparam int IRQ_PHANTOM = 0;
  localparam int IRQ_PDP = 1;

  // pin order of the synchroniser bank
  localparam int PIN_NMI = 3;
  localparam int PIN_PDP = 4;

  localparam int GA_N = 11;
  localparam int GB_N = 8;
  localparam int GC_N = 4;
  localparam int SYS_N = 13;

  localparam logic [15:0] PHANTOM_OFFSET = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // index 0 is the highest priority
  localparam logic [GA_N-1:0][15:0] GA_OFFS = {16'h002A, 16'h0029, 16'h0028, 16'h0027, 16'h0026, 16'h0025,
                                               16'h0024, 16'h0023, 16'h0022, 16'h0021, 16'h0020};
  localparam logic [GB_N-1:0][15:0] GB_OFFS = {16'h0032, 16'h0031, 16'h0030, 16'h002F, 16'h002E, 16'h002D,
                                               16'h002C, 16'h002B};
  localparam logic [GC_N-1:0][15:0] GC_OFFS = {16'h0036, 16'h0035, 16'h0034, 16'h0033};
  localparam logic [SYS_N-1:0][15:0] SYS_OFFS = {16'h001F, 16'h0011, 16'h0001, 16'h0004, 16'h0007, 16'h0006,
                                                 16'h0005, 16'h0007, 16'h0006, 16'h0005, 16'h001F, 16'h0011,
                                                 16'h0001};

endpackage : pie_pkg
